// file: rtl/sfp_defs.vh
// Constants for the serial flash erase, program and power-down sequencer.
//
// Overview of operation
// - Sector erase sets one 4 KB sector, chosen by address bits 12 up, to ones.
// - Sector erase is opcode plus 3 address bytes; rejected off byte boundary.
// - Timed erase or program cycles start at the accepting chip select rise.
// - Write in progress is 1 for the cycle; at the end it and latch clear.
// - A sector covered by the protect bits is not erased.
// - Half block erase sets a 32 KB block to ones, same framing rules.
// - Protected half block stays unchanged but the enable latch still clears.
// - Block erase sets a 64 KB block to ones with a busy cycle, unless protected.
// - Chip erase is opcode only; rejected unless chip select rises on boundary.
// - Chip erase runs only when all four protect bits are zero.
// - Page program clears bits, opcode 02h, then 24-bit address and data.
// - Beyond 256 data bytes only the last 256 are programmed.
// - Program address wraps inside the 256-byte page.
// - Fewer than 256 bytes leave the rest of the page untouched.
// - Program needs one or more whole data bytes; else it is rejected.
// - Four-line program takes address and data on four lines.
// - Single-line commands ignore the upper three data lines.
// - Power-down on byte boundary, entered after entry delay, then deaf.
// - Release by long chip select low pulse, then recovery delay; reset releases at once.
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH

`define SFP_CLK_NS 8

// Opcodes.
`define SFP_OP_WRITE_ENABLE 8'h06
`define SFP_OP_SECTOR_ERASE 8'h20
`define SFP_OP_HALF_BLOCK_ERASE 8'h52
`define SFP_OP_BLOCK_ERASE 8'hD8
`define SFP_OP_CHIP_ERASE 8'hC7
`define SFP_OP_PAGE_PROGRAM 8'h02
`define SFP_OP_QUAD_PAGE_PROGRAM 8'h38
`define SFP_OP_DEEP_POWERDOWN 8'hB9

// Erase kinds reported with an erase start.
`define SFP_ERASE_SECTOR 2'h0
`define SFP_ERASE_HALF_BLOCK 2'h1
`define SFP_ERASE_BLOCK 2'h2
`define SFP_ERASE_CHIP 2'h3

// Address field positions.
`define SFP_SECTOR_LSB 12
`define SFP_HALF_BLOCK_LSB 15
`define SFP_BLOCK_LSB 16

// Byte counts of a frame.
`define SFP_BYTES_AFTER_ADDR 3'h4
`define SFP_BYTES_WITH_DATA 3'h5

// Times, long ones in microseconds and short ones in nanoseconds.
`define SFP_SECTOR_ERASE_TIME_US 60000
`define SFP_HALF_BLOCK_ERASE_TIME_US 200000
`define SFP_BLOCK_ERASE_TIME_US 400000
`define SFP_CHIP_ERASE_TIME_US 10000000
`define SFP_PAGE_PROGRAM_TIME_US 1400
`define SFP_POWERDOWN_ENTRY_DELAY_NS 3000
`define SFP_POWERDOWN_MIN_DWELL_NS 30000
`define SFP_RELEASE_PULSE_TIME_NS 20
`define SFP_RELEASE_RECOVERY_DELAY_NS 8800

// Cycle counts; least times round up.
`define SFP_US_CYC(t) ((t) * (1000 / `SFP_CLK_NS))
`define SFP_NS_CYC_UP(t) (((t) + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_SECTOR_ERASE_CYC `SFP_US_CYC(`SFP_SECTOR_ERASE_TIME_US)
`define SFP_HALF_BLOCK_ERASE_CYC `SFP_US_CYC(`SFP_HALF_BLOCK_ERASE_TIME_US)
`define SFP_BLOCK_ERASE_CYC `SFP_US_CYC(`SFP_BLOCK_ERASE_TIME_US)
`define SFP_CHIP_ERASE_CYC `SFP_US_CYC(`SFP_CHIP_ERASE_TIME_US)
`define SFP_PAGE_PROGRAM_CYC `SFP_US_CYC(`SFP_PAGE_PROGRAM_TIME_US)
`define SFP_ENTRY_CYC `SFP_NS_CYC_UP(`SFP_POWERDOWN_ENTRY_DELAY_NS)
`define SFP_RELEASE_CYC `SFP_NS_CYC_UP(`SFP_RELEASE_PULSE_TIME_NS)
`define SFP_RECOVERY_CYC `SFP_NS_CYC_UP(`SFP_RELEASE_RECOVERY_DELAY_NS)

`endif

// file: rtl/sfp_page_buf.v
// Page buffer with a per-byte written mask for page program data.
`timescale 1ns/1ps
module sfp_page_buf #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk,             // Core clock.
  input wire rst,             // Asynchronous reset, active high.
  input wire clr,             // Clears every written mark.
  input wire wr_en,           // Write one byte.
  input wire [AW-1:0] wr_addr, // Write byte position.
  input wire [DW-1:0] wr_data, // Write byte.
  input wire [AW-1:0] rd_addr, // Read byte position.
  output reg [DW-1:0] rd_data, // Byte read, one cycle later.
  output reg rd_mark          // Byte was written since the last clear.
);

  localparam DEPTH = 1 << AW;

  reg [DW-1:0] mem [0:DEPTH-1];
  reg [DEPTH-1:0] mark;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

  // A later byte at the same position simply overwrites the earlier one.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mark <= {DEPTH{1'b0}};
      rd_mark <= 1'b0;
    end
    else
    begin
      if (clr)
      begin
        mark <= {DEPTH{1'b0}};
      end
      else if (wr_en)
      begin
        mark[wr_addr] <= 1'b1;
      end
      rd_mark <= mark[rd_addr];
    end
  end

endmodule // sfp_page_buf

// file: rtl/sfp_seq.v
// Command decoder and self-timed sequencer for erase, program, power-down.
`timescale 1ns/1ps
`include "sfp_defs.vh"
module sfp_seq #(
  parameter ADDR_W = 21,
  parameter [31:0] SECTOR_CYC = `SFP_SECTOR_ERASE_CYC,
  parameter [31:0] HALF_BLOCK_CYC = `SFP_HALF_BLOCK_ERASE_CYC,
  parameter [31:0] BLOCK_CYC = `SFP_BLOCK_ERASE_CYC,
  parameter [31:0] CHIP_CYC = `SFP_CHIP_ERASE_CYC,
  parameter [31:0] PAGE_CYC = `SFP_PAGE_PROGRAM_CYC,
  parameter [31:0] ENTRY_CYC = `SFP_ENTRY_CYC,
  parameter [31:0] RELEASE_CYC = `SFP_RELEASE_CYC,
  parameter [31:0] RECOVERY_CYC = `SFP_RECOVERY_CYC
) (
  input wire core_clk,            // Core clock, 125 MHz.
  input wire rst,                 // Asynchronous reset, active high.
  input wire cs_n,                // Chip select pin, active low.
  input wire sclk,                // Serial clock pin.
  input wire [3:0] sio_in,        // Data lines in.
  input wire [3:0] block_protect, // Protect bits 3 down to 0.
  input wire quad_enable,         // Four-line program allowed.
  output reg write_enable_latch,  // Write enable latch.
  output reg write_in_progress,   // Timed cycle running.
  output reg deep_powerdown,      // In deep power-down.
  output reg erase_start,         // One-cycle pulse: erase region.
  output reg [1:0] erase_kind,    // Region size of the erase.
  output reg [ADDR_W-1:0] erase_addr, // Region base address.
  output reg prog_we,             // One-cycle pulse: program one byte.
  output reg [ADDR_W-1:0] prog_addr, // Byte address to program.
  output reg [7:0] prog_data      // Byte to program, ones stay.
);

  localparam PD_NONE = 2'h0;
  localparam PD_ENTER = 2'h1;
  localparam PD_DEEP = 2'h2;
  localparam PD_RECOVER = 2'h3;

  // A region is covered when it lies in the top 64 KB blocks selected.
  function prot_hit;
    input [ADDR_W-1:0] a;
    input [3:0] bp;
    integer blk;
    integer total;
    integer nprot;
    begin
      blk = a >> `SFP_BLOCK_LSB;
      total = 1 << (ADDR_W - `SFP_BLOCK_LSB);
      nprot = 1 << bp;
      nprot = nprot / 2;
      if (bp == 4'h0)
        prot_hit = 1'b0;
      else if (nprot >= total)
        prot_hit = 1'b1;
      else
        prot_hit = (blk >= total - nprot);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.
  reg cs_m, cs_s, cs_q;
  reg sclk_m, sclk_s, sclk_q;
  reg [3:0] sio_m, sio_s;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_q <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_q <= 1'b0;
      sio_m <= 4'h0;
      sio_s <= 4'h0;
    end
    else
    begin
      cs_m <= cs_n;
      cs_s <= cs_m;
      cs_q <= cs_s;
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_q <= sclk_s;
      sio_m <= sio_in;
      sio_s <= sio_m;
    end
  end

  wire cs_rise = cs_s & ~cs_q;
  wire cs_fall = ~cs_s & cs_q;
  wire sclk_rise = sclk_s & ~sclk_q & ~cs_s;

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembly: opcode, three address bytes, then data bytes.
  reg [7:0] shreg;
  reg [7:0] opcode;
  reg [23:0] addr;
  reg [3:0] bitcnt;
  reg [2:0] byte_idx;
  reg [7:0] dcnt;
  reg [1:0] pd_state;

  wire lane4 = (opcode == `SFP_OP_QUAD_PAGE_PROGRAM) && quad_enable &&
               (byte_idx != 3'h0);
  // Single-line framing only looks at line 0.
  wire [7:0] next_sh = lane4 ? {shreg[3:0], sio_s} :
                       {shreg[6:0], sio_s[0]};
  wire [3:0] next_bitcnt = bitcnt + (lane4 ? 4'h4 : 4'h1);
  wire byte_done = sclk_rise && (next_bitcnt == 4'h8);
  wire is_prog_op = (opcode == `SFP_OP_PAGE_PROGRAM) ||
                    (opcode == `SFP_OP_QUAD_PAGE_PROGRAM);

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      shreg <= 8'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
      bitcnt <= 4'h0;
      byte_idx <= 3'h0;
      dcnt <= 8'h00;
    end
    else if (cs_s)
    begin
      bitcnt <= 4'h0;
      byte_idx <= 3'h0;
      dcnt <= 8'h00;
    end
    else if (sclk_rise)
    begin
      shreg <= next_sh;
      if (byte_done)
      begin
        bitcnt <= 4'h0;
        if (byte_idx != `SFP_BYTES_WITH_DATA)
        begin
          byte_idx <= byte_idx + 3'h1;
        end
        case (byte_idx)
          3'h0: opcode <= next_sh;
          3'h1: addr[23:16] <= next_sh;
          3'h2: addr[15:8] <= next_sh;
          3'h3: addr[7:0] <= next_sh;
          default: dcnt <= dcnt + 8'h01;
        endcase
      end
      else
      begin
        bitcnt <= next_bitcnt;
      end
    end
  end

  // Data bytes land at the page offset plus count, wrapping in the page,
  // so past 256 bytes the oldest ones are overwritten.
  wire buf_wr = byte_done && is_prog_op &&
                (byte_idx >= `SFP_BYTES_AFTER_ADDR) &&
                !write_in_progress && (pd_state == PD_NONE);
  wire [7:0] buf_wr_addr = addr[7:0] + dcnt;
  wire buf_clr = cs_fall && !write_in_progress;
  reg [7:0] idx;
  wire [7:0] buf_data;
  wire buf_mark;

  sfp_page_buf #(
    .AW(8),
    .DW(8)
  ) u_page_buf (
    .clk(core_clk),
    .rst(rst),
    .clr(buf_clr),
    .wr_en(buf_wr),
    .wr_addr(buf_wr_addr),
    .wr_data(next_sh),
    .rd_addr(idx),
    .rd_data(buf_data),
    .rd_mark(buf_mark)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at the chip select rise.
  wire [ADDR_W-1:0] a = addr[ADDR_W-1:0];
  wire on_boundary = (bitcnt == 4'h0);
  wire cmd_ok = cs_rise && on_boundary && (pd_state == PD_NONE) &&
                !write_in_progress;
  wire one_byte = (byte_idx == 3'h1);
  wire addr_only = (byte_idx == `SFP_BYTES_AFTER_ADDR);
  wire do_write_enable_cmd = cmd_ok && one_byte &&
                 (opcode == `SFP_OP_WRITE_ENABLE);
  wire do_se = cmd_ok && addr_only && write_enable_latch &&
               (opcode == `SFP_OP_SECTOR_ERASE);
  wire do_hbe = cmd_ok && addr_only && write_enable_latch &&
                (opcode == `SFP_OP_HALF_BLOCK_ERASE);
  wire do_be = cmd_ok && addr_only && write_enable_latch &&
               (opcode == `SFP_OP_BLOCK_ERASE);
  wire do_ce = cmd_ok && one_byte && write_enable_latch &&
               (opcode == `SFP_OP_CHIP_ERASE);
  wire do_pp = cmd_ok && (byte_idx == `SFP_BYTES_WITH_DATA) &&
               write_enable_latch &&
               ((opcode == `SFP_OP_PAGE_PROGRAM) ||
                ((opcode == `SFP_OP_QUAD_PAGE_PROGRAM) && quad_enable));
  wire do_dp = cmd_ok && one_byte &&
               (opcode == `SFP_OP_DEEP_POWERDOWN);

  wire [ADDR_W-1:0] sector_base = {a[ADDR_W-1:`SFP_SECTOR_LSB],
                                   {`SFP_SECTOR_LSB{1'b0}}};
  wire [ADDR_W-1:0] half_base = {a[ADDR_W-1:`SFP_HALF_BLOCK_LSB],
                                 {`SFP_HALF_BLOCK_LSB{1'b0}}};
  wire [ADDR_W-1:0] block_base = {a[ADDR_W-1:`SFP_BLOCK_LSB],
                                  {`SFP_BLOCK_LSB{1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // Latch, busy timer, erase start, program streaming.
  reg [31:0] busy_cnt;
  reg streaming;
  reg stream_d;
  reg [7:0] idx_d;
  reg [ADDR_W-9:0] page;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      write_enable_latch <= 1'b0;
      write_in_progress <= 1'b0;
      busy_cnt <= 32'h00000000;
      erase_start <= 1'b0;
      erase_kind <= 2'h0;
      erase_addr <= {ADDR_W{1'b0}};
      streaming <= 1'b0;
      stream_d <= 1'b0;
      idx <= 8'h00;
      idx_d <= 8'h00;
      page <= {(ADDR_W-8){1'b0}};
      prog_we <= 1'b0;
      prog_addr <= {ADDR_W{1'b0}};
      prog_data <= 8'h00;
    end
    else
    begin
      erase_start <= 1'b0;
      stream_d <= streaming;
      idx_d <= idx;
      // Only bytes marked as received are programmed.
      prog_we <= stream_d & buf_mark;
      prog_addr <= {page, idx_d};
      prog_data <= buf_data;
      if (streaming)
      begin
        idx <= idx + 8'h01;
        if (idx == 8'hFF)
        begin
          streaming <= 1'b0;
        end
      end
      if (write_in_progress)
      begin
        busy_cnt <= busy_cnt - 32'h00000001;
        if (busy_cnt == 32'h00000001)
        begin
          write_in_progress <= 1'b0;
          write_enable_latch <= 1'b0;
        end
      end
      if (do_write_enable_cmd)
      begin
        write_enable_latch <= 1'b1;
      end
      if (do_se)
      begin
        if (prot_hit(sector_base, block_protect))
          write_enable_latch <= 1'b0;
        else
        begin
          write_in_progress <= 1'b1;
          busy_cnt <= SECTOR_CYC;
          erase_start <= 1'b1;
          erase_kind <= `SFP_ERASE_SECTOR;
          erase_addr <= sector_base;
        end
      end
      if (do_hbe)
      begin
        if (prot_hit(half_base, block_protect))
          write_enable_latch <= 1'b0;
        else
        begin
          write_in_progress <= 1'b1;
          busy_cnt <= HALF_BLOCK_CYC;
          erase_start <= 1'b1;
          erase_kind <= `SFP_ERASE_HALF_BLOCK;
          erase_addr <= half_base;
        end
      end
      if (do_be)
      begin
        if (prot_hit(block_base, block_protect))
          write_enable_latch <= 1'b0;
        else
        begin
          write_in_progress <= 1'b1;
          busy_cnt <= BLOCK_CYC;
          erase_start <= 1'b1;
          erase_kind <= `SFP_ERASE_BLOCK;
          erase_addr <= block_base;
        end
      end
      if (do_ce)
      begin
        if (block_protect != 4'h0)
          write_enable_latch <= 1'b0;
        else
        begin
          write_in_progress <= 1'b1;
          busy_cnt <= CHIP_CYC;
          erase_start <= 1'b1;
          erase_kind <= `SFP_ERASE_CHIP;
          erase_addr <= {ADDR_W{1'b0}};
        end
      end
      if (do_pp)
      begin
        if (prot_hit(a, block_protect))
          write_enable_latch <= 1'b0;
        else
        begin
          write_in_progress <= 1'b1;
          busy_cnt <= PAGE_CYC;
          streaming <= 1'b1;
          idx <= 8'h00;
          page <= a[ADDR_W-1:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Deep power-down entry, release and recovery.
  reg [31:0] pd_cnt;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pd_state <= PD_NONE;
      pd_cnt <= 32'h00000000;
      deep_powerdown <= 1'b0;
    end
    else
    begin
      case (pd_state)
        PD_NONE:
        begin
          pd_cnt <= 32'h00000000;
          if (do_dp)
          begin
            pd_state <= PD_ENTER;
          end
        end
        PD_ENTER:
        begin
          pd_cnt <= pd_cnt + 32'h00000001;
          if (pd_cnt + 32'h00000001 >= ENTRY_CYC)
          begin
            pd_state <= PD_DEEP;
            deep_powerdown <= 1'b1;
            pd_cnt <= 32'h00000000;
          end
        end
        PD_DEEP:
        begin
          if (cs_rise)
          begin
            pd_cnt <= 32'h00000000;
            if (pd_cnt >= RELEASE_CYC)
            begin
              pd_state <= PD_RECOVER;
            end
          end
          else if (!cs_s)
          begin
            if (pd_cnt < RELEASE_CYC)
            begin
              pd_cnt <= pd_cnt + 32'h00000001;
            end
          end
          else
          begin
            pd_cnt <= 32'h00000000;
          end
        end
        PD_RECOVER:
        begin
          pd_cnt <= pd_cnt + 32'h00000001;
          if (pd_cnt + 32'h00000001 >= RECOVERY_CYC)
          begin
            pd_state <= PD_NONE;
            deep_powerdown <= 1'b0;
            pd_cnt <= 32'h00000000;
          end
        end
        default:
        begin
          pd_state <= PD_NONE;
          pd_cnt <= 32'h00000000;
        end
      endcase
    end
  end

endmodule // sfp_seq

// file: tb/sfp_seq_assertions.sv
// Port checker for the flash erase, program and power-down sequencer.
`timescale 1ns/1ps
module sfp_seq_assertions #(
  parameter ADDR_W = 21,
  parameter [31:0] SECTOR_CYC = 50,
  parameter [31:0] HALF_BLOCK_CYC = 50,
  parameter [31:0] BLOCK_CYC = 50,
  parameter [31:0] CHIP_CYC = 50,
  parameter [31:0] PAGE_CYC = 300
) (
  input wire core_clk, // Core clock.
  input wire rst, // Reset, active high.
  input wire cs_n, // Chip select pin.
  input wire [3:0] block_protect, // Protect bits.
  input wire write_enable_latch, // Enable latch.
  input wire write_in_progress, // Busy flag.
  input wire deep_powerdown, // Deep state.
  input wire erase_start, // Erase pulse.
  input wire [1:0] erase_kind, // Erase size.
  input wire [ADDR_W-1:0] erase_addr, // Erase base.
  input wire prog_we, // Program pulse.
  input wire [ADDR_W-1:0] prog_addr // Program address.
);
  reg [31:0] busy_cnt;
  reg [31:0] busy_len;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Busy cycles so far, and the length the running cycle must reach.
  always @(posedge core_clk or posedge rst)
    if (rst)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= write_in_progress ? busy_cnt + 32'h1 : 32'h0;
  always @(posedge core_clk or posedge rst)
    if (rst)
      busy_len <= 32'h0;
    else if (write_in_progress && busy_cnt == 32'h0)
      busy_len <= !erase_start ? PAGE_CYC : erase_kind == 2'h0 ? SECTOR_CYC :
        erase_kind == 2'h1 ? HALF_BLOCK_CYC :
        erase_kind == 2'h2 ? BLOCK_CYC : CHIP_CYC;
  ////////////////////////////////////////////////////////////
  sequence cyc_start;
    $rose(write_in_progress);
  endsequence
  sequence cyc_end;
    $fell(write_in_progress);
  endsequence
  start_at_cs_a: assert property (cyc_start |-> cs_n &&
    $past(cs_n, 2) && !$past(cs_n, 8)) else $error("cycle not at cs rise");
  start_needs_latch_a: assert property (cyc_start |->
    write_enable_latch && $past(write_enable_latch))
    else $error("cycle without latch");
  busy_length_a: assert property (cyc_end |-> busy_cnt == busy_len)
    else $error("busy length wrong");
  latch_clear_a: assert property (cyc_end |->
    $past(write_enable_latch) && !write_enable_latch)
    else $error("latch not cleared at end");
  erase_with_busy_a: assert property (erase_start |-> cyc_start)
    else $error("erase pulse without busy rise");
  erase_single_a: assert property (erase_start |=>
    (!erase_start && write_in_progress) [*8]) else $error("second erase");
  erase_base_a: assert property (erase_start |->
    (erase_kind == 2'h0 && erase_addr[11:0] == 12'h0) ||
    (erase_kind == 2'h1 && erase_addr[14:0] == 15'h0) ||
    (erase_kind == 2'h2 && erase_addr[15:0] == 16'h0) ||
    (erase_kind == 2'h3 && erase_addr == 0)) else $error("erase base");
  chip_unprotected_a: assert property (erase_start &&
    erase_kind == 2'h3 |-> block_protect == 4'h0)
    else $error("chip erase while protected");
  prog_in_busy_a: assert property (prog_we |-> write_in_progress)
    else $error("program byte outside cycle");
  prog_wrap_a: assert property (prog_we && $past(prog_we) |->
    prog_addr[ADDR_W-1:8] == $past(prog_addr[ADDR_W-1:8]) &&
    prog_addr[7:0] == $past(prog_addr[7:0]) + 8'h01)
    else $error("program address order");
  deep_deaf_a: assert property (deep_powerdown |->
    !$rose(write_in_progress) && !prog_we && !erase_start)
    else $error("activity in power-down");
endmodule // sfp_seq_assertions

// file: tb/sfp_host.sv
// Host controller model driving chip select, serial clock and data lines.
`timescale 1ns/1ps
module sfp_host (
  output logic cs_n, // Chip select, active low.
  output logic sclk, // Serial clock, still outside frames.
  output logic [3:0] sio // Data lines.
);
  logic [7:0] tx_q [$];
  logic [2:0] spin;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sio = 4'h5;
    spin = 3'h0;
  end
  task shift(input logic [3:0] v);
  begin
    sio = v;
    #62.5 sclk = 1'b1;
    #62.5 sclk = 1'b0;
    spin = spin + 3'h3;
  end
  endtask
  // Sends the queued bytes; quad puts bytes after the opcode on four lines.
  task send(input bit quad, input int extra);
    int i;
    int n;
  begin
    cs_n = 1'b0;
    for (i = 0; i < tx_q.size(); i++)
      if (quad && i > 0)
      begin
        shift(tx_q[i][7:4]);
        shift(tx_q[i][3:0]);
      end
      else
        for (n = 7; n >= 0; n--)
          shift({spin, tx_q[i][n]});
    for (n = 0; n < extra; n++)
      shift({spin, 1'b1});
    #62.5 cs_n = 1'b1;
    sio = ~sio;
    tx_q.delete();
    #200;
  end
  endtask
  // Chip select low with the clock still ends power-down.
  task wake;
  begin
    cs_n = 1'b0;
    #100 cs_n = 1'b1;
    #200;
  end
  endtask
endmodule // sfp_host

// file: tb/tb_top.sv
// Bench for the flash sequencer driven through the host model.
`timescale 1ns/1ps
`include "sfp_defs.vh"
module tb_top;
  typedef struct {
    logic prog;
    logic [1:0] kind;
    logic [20:0] addr;
    logic [7:0] data;
  } sfp_note_t;
  logic core_clk;
  logic rst;
  logic quad_enable;
  logic [3:0] block_protect;
  wire [3:0] sio;
  wire [1:0] erase_kind;
  wire [20:0] erase_addr, prog_addr;
  wire [7:0] prog_data;
  wire write_enable_latch, write_in_progress, deep_powerdown;
  wire cs_n, sclk, erase_start, prog_we;
  sfp_note_t exp_q [$];
  sfp_note_t got;
  logic [7:0] d [0:299];
  logic [7:0] ops [0:3] = '{`SFP_OP_SECTOR_ERASE, `SFP_OP_HALF_BLOCK_ERASE,
    `SFP_OP_BLOCK_ERASE, `SFP_OP_CHIP_ERASE};
  logic [20:0] mask [0:3] = '{21'h1FF000, 21'h1F8000, 21'h1F0000, 21'h0};
  logic [23:0] a;
  integer seed;
  int n_mismatch;
  int comparisons;
  int k;
  sfp_host host (.cs_n(cs_n), .sclk(sclk), .sio(sio));
  // Short timed cycles keep the run small; the program must outlast its
  // 259-cycle byte stream.
  localparam [31:0] SE_CYC = 50, HB_CYC = 60, BE_CYC = 70, CE_CYC = 2000;
  localparam [31:0] PP_CYC = 300, DP_CYC = 10, RL_CYC = 3, RC_CYC = 20;
  sfp_seq #(.SECTOR_CYC(SE_CYC), .HALF_BLOCK_CYC(HB_CYC),
    .BLOCK_CYC(BE_CYC), .CHIP_CYC(CE_CYC), .PAGE_CYC(PP_CYC),
    .ENTRY_CYC(DP_CYC), .RELEASE_CYC(RL_CYC),
    .RECOVERY_CYC(RC_CYC)) dut (
    .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sio_in(sio),
    .block_protect(block_protect), .quad_enable(quad_enable),
    .write_enable_latch(write_enable_latch),
    .write_in_progress(write_in_progress), .deep_powerdown(deep_powerdown),
    .erase_start(erase_start), .erase_kind(erase_kind),
    .erase_addr(erase_addr), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_data(prog_data));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] want);
  begin
    comparisons++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, wanted %h", $time, seen, want);
    end
  end
  endtask
  task final_report;
  begin
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // Sends the queued frame, then waits out any timed cycle it started.
  task run(input bit quad, input int extra);
    int i;
  begin
    @(posedge core_clk);
    #1 host.send(quad, extra);
    repeat (6) @(posedge core_clk);
    for (i = 0; write_in_progress !== 1'b0; i++)
    begin
      if (i == 5000)
      begin
        n_mismatch++;
        final_report();
      end
      @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  end
  endtask
  task frame(input logic [7:0] op, input bit with_addr, input logic [23:0] x);
  begin
    host.tx_q.push_back(op);
    if (with_addr)
    begin
      host.tx_q.push_back(x[23:16]);
      host.tx_q.push_back(x[15:8]);
      host.tx_q.push_back(x[7:0]);
    end
  end
  endtask
  task write_enable_cmd;
  begin
    frame(`SFP_OP_WRITE_ENABLE, 1'b0, a);
    run(1'b0, 0);
  end
  endtask
  // Program of n random bytes; notes the last byte landing on each offset.
  task prog(input bit quad, input logic [7:0] off, input int n);
    int o;
    int m;
  begin
    a = $random(seed);
    a = {3'h0, a[20:8], off};
    frame(quad ? `SFP_OP_QUAD_PAGE_PROGRAM : `SFP_OP_PAGE_PROGRAM, 1'b1, a);
    for (m = 0; m < n; m++)
    begin
      d[m] = $random(seed);
      host.tx_q.push_back(d[m]);
    end
    for (o = 0; o < 256; o++)
    begin
      m = (o - off) & 255;
      while (m + 256 < n)
        m += 256;
      if (m < n)
        exp_q.push_back('{1'b1, 2'h0, {a[20:8], o[7:0]}, d[m]});
    end
    run(quad, 0);
  end
  endtask
  always @(posedge core_clk)
    if (rst === 1'b0 && (erase_start === 1'b1 || prog_we === 1'b1))
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        got = exp_q.pop_front();
        check(prog_we, got.prog);
        if (got.prog)
          check({prog_addr, prog_data}, {got.addr, got.data});
        else
          check({erase_kind, erase_addr}, {got.kind, got.addr});
      end
    end
  ////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h9C5744F2;
    n_mismatch = 0;
    comparisons = 0;
    rst = 1'b1;
    quad_enable = 1'b0;
    block_protect = 4'h0;
    a = 24'h0;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    for (k = 0; k < 4; k++)
    begin
      write_enable_cmd();
      check(write_enable_latch, 1'b1);
      a = $random(seed);
      a[23:21] = 3'h0;
      frame(ops[k], k < 3, a);
      exp_q.push_back('{1'b0, k[1:0], a[20:0] & mask[k], 8'h00});
      run(1'b0, 0);
      check(write_enable_latch, 1'b0);
    end
    frame(`SFP_OP_SECTOR_ERASE, 1'b1, a);
    run(1'b0, 0);
    write_enable_cmd();
    frame(`SFP_OP_SECTOR_ERASE, 1'b1, a);
    run(1'b0, 3);
    frame(`SFP_OP_CHIP_ERASE, 1'b0, a);
    run(1'b0, 1);
    frame(`SFP_OP_PAGE_PROGRAM, 1'b1, a);
    run(1'b0, 0);
    frame(`SFP_OP_PAGE_PROGRAM, 1'b1, a);
    host.tx_q.push_back(8'hA5);
    run(1'b0, 4);
    frame(`SFP_OP_QUAD_PAGE_PROGRAM, 1'b1, a);
    host.tx_q.push_back(8'h3C);
    run(1'b1, 0);
    check(write_enable_latch, 1'b1);
    prog(1'b0, 8'hFE, 3);
    write_enable_cmd();
    quad_enable = 1'b1;
    prog(1'b1, 8'h37, 260);
    check(write_enable_latch, 1'b0);
    block_protect = 4'h1;
    for (k = 0; k < 4; k++)
    begin
      write_enable_cmd();
      frame(ops[k], k < 3, 24'h1F9123);
      run(1'b0, 0);
      check(write_enable_latch, 1'b0);
    end
    block_protect = 4'h0;
    write_enable_cmd();
    frame(`SFP_OP_CHIP_ERASE, 1'b0, a);
    exp_q.push_back('{1'b0, 2'h3, 21'h0, 8'h00});
    @(posedge core_clk);
    #1 host.send(1'b0, 0);
    frame(`SFP_OP_SECTOR_ERASE, 1'b1, a);
    run(1'b0, 0);
    check(write_enable_latch, 1'b0);
    frame(`SFP_OP_DEEP_POWERDOWN, 1'b0, a);
    run(1'b0, 2);
    repeat (12) @(posedge core_clk);
    check(deep_powerdown, 1'b0);
    frame(`SFP_OP_DEEP_POWERDOWN, 1'b0, a);
    run(1'b0, 0);
    repeat (12) @(posedge core_clk);
    check(deep_powerdown, 1'b1);
    #30000;
    write_enable_cmd();
    check(write_enable_latch, 1'b0);
    host.wake();
    repeat (25) @(posedge core_clk);
    check(deep_powerdown, 1'b0);
    write_enable_cmd();
    check(write_enable_latch, 1'b1);
    frame(`SFP_OP_DEEP_POWERDOWN, 1'b0, a);
    run(1'b0, 0);
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b1;
    @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge core_clk);
    check({deep_powerdown, write_enable_latch}, 2'h0);
    check(exp_q.size(), 0);
    final_report();
  end
endmodule // tb_top
bind sfp_seq sfp_seq_assertions #(.ADDR_W(ADDR_W), .SECTOR_CYC(SECTOR_CYC),
  .HALF_BLOCK_CYC(HALF_BLOCK_CYC), .BLOCK_CYC(BLOCK_CYC),
  .CHIP_CYC(CHIP_CYC), .PAGE_CYC(PAGE_CYC)) chk (
  .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .block_protect(block_protect),
  .write_enable_latch(write_enable_latch),
  .write_in_progress(write_in_progress), .deep_powerdown(deep_powerdown),
  .erase_start(erase_start), .erase_kind(erase_kind),
  .erase_addr(erase_addr), .prog_we(prog_we), .prog_addr(prog_addr));
